/* dv/ssq_partner.sv */
`timescale 1ns/1ps
module ssq_partner
    import ssq_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic signed [15:0] speed_demand,
    input  wire logic signed [15:0] fb_ofs,
    output logic signed [15:0]      speed_feedback,
    output logic signed [15:0]      standstill_demand
);
    // motor lags demand one cycle; offset stands for load drift
    always_ff @(posedge sys_clk) begin
        speed_feedback <= speed_demand + fb_ofs;
    end
    assign standstill_demand = speed_demand;
endmodule

/* dv/ssq_properties.sv */
`timescale 1ns/1ps
module ssq_properties
    import ssq_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               sys_rst,
    input wire logic [7:0]         reg_addr,
    input wire logic [31:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               freewheel_n,
    input wire logic               enable_in,
    input wire logic signed [15:0] speed_feedback,
    input wire logic signed [15:0] standstill_demand,
    input wire ssq_drive_type      drive_ctl,
    input wire logic               speed_near_zero,
    input wire logic               demand_near_zero,
    input wire logic               motor_stopped_flag,
    input wire logic               not_motor_stopped_flag,
    input wire logic               zero_speed_relay
);
    logic [15:0] zl;
    logic [15:0] next_zl;
    wire  [15:0] fb_mag = speed_feedback[15] ? -speed_feedback : speed_feedback;
    wire  [15:0] sd_mag = standstill_demand[15] ? -standstill_demand : standstill_demand;
    // shadow of the zero level, so flag edges can be judged
    always_comb begin
        next_zl = sys_rst ? RST_ZERO_LEVEL : zl;
        if (reg_wr && reg_addr == OFS_ZERO_LEVEL)
            next_zl = reg_wdata[15:0];
    end
    always_ff @(posedge sys_clk) begin
        zl <= next_zl;
    end
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    chk_stopped_both: assert property (
        motor_stopped_flag == (speed_near_zero && demand_near_zero)) else $error("bad stopped");
    chk_standstill_inverse: assert property (
        not_motor_stopped_flag != motor_stopped_flag) else $error("standstill output not inverse");
    chk_relay_follows: assert property (
        zero_speed_relay == speed_near_zero) else $error("relay differs from speed flag");
    chk_speed_sets: assert property (
        $rose(speed_near_zero) |-> $past(fb_mag) < $past(zl)) else $error("speed flag set high");
    chk_speed_clears: assert property (
        $fell(speed_near_zero) |-> $past(fb_mag) > $past(zl) + HYST_BAND)
        else $error("speed flag cleared inside band");
    chk_demand_sets: assert property (
        $rose(demand_near_zero) |-> $past(sd_mag) < $past(zl)) else $error("demand flag set high");
    chk_freewheel_off: assert property (
        !freewheel_n [*6] |-> !drive_ctl.drive_enable && !drive_ctl.contactor_on)
        else $error("freewheel left drive on");
    chk_enable_resets: assert property (
        !enable_in [*6] |-> drive_ctl.loop_reset) else $error("loops not reset");
endmodule
bind ssq_top ssq_properties i_ssq_properties (.sys_clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .freewheel_n, .enable_in, .speed_feedback, .standstill_demand, .drive_ctl,
    .speed_near_zero, .demand_near_zero, .motor_stopped_flag, .not_motor_stopped_flag,
    .zero_speed_relay);

/* dv/ssq_top_tb.sv */
`timescale 1ns/1ps
module ssq_top_tb
    import ssq_pkg::*;
;
    logic        sys_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, ez = 1'h1;
    logic        run_cmd = 1'h0, fast_stop_n = 1'h1, freewheel_n = 1'h1, enable_in = 1'h1;
    logic        override_limit_active = 1'h0, speed_near_zero, demand_near_zero;
    logic        motor_stopped_flag, not_motor_stopped_flag, zero_speed_relay;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [15:0] normal_current_limit = 16'h2710, override_current_limit = 16'h4E20;
    logic [15:0] main_current_limit, cap;
    logic signed [15:0] speed_setpoint = 16'h0, fb_ofs = 16'h0, current_demand = 16'sd100;
    logic signed [15:0] speed_feedback, standstill_demand, speed_demand, current_command;
    ssq_drive_type drive_ctl;
    int          n_mismatch = 0, n_checks = 0, cyc, x, seed = 32'h36E3B14E;

    always #50 sys_clk = ~sys_clk;

    ssq_top #(.TICK_CYCLES(100), .STEP_CYCLES(1), .FALL_CYCLES(1000)) i_ssq_top (
        .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .run_cmd,
        .fast_stop_n, .freewheel_n, .enable_in, .speed_feedback, .speed_setpoint,
        .standstill_demand, .current_demand, .normal_current_limit, .override_current_limit,
        .override_limit_active, .speed_demand, .current_command, .main_current_limit,
        .drive_ctl, .speed_near_zero, .demand_near_zero, .motor_stopped_flag,
        .not_motor_stopped_flag, .zero_speed_relay);
    ssq_partner i_ssq_partner (.sys_clk, .speed_demand, .fb_ofs, .speed_feedback,
        .standstill_demand);

    task conclude;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= {16'h0000, d};
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
        @(posedge sys_clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        @(posedge sys_clk);
        chk(e, reg_rdata);
    endtask
    // bounded wait on the contactor; a hang ends the run
    task wc(input logic v, input int n);
        for (cyc = 0; drive_ctl.contactor_on !== v; cyc++) begin
            if (cyc >= n) begin
                n_mismatch++;
                conclude;
            end
            @(posedge sys_clk);
        end
    endtask
    function automatic logic nz(input logic p, input int v);
        v = v < 0 ? -v : v;
        return v < RST_ZERO_LEVEL ? 1'h1 : (v > RST_ZERO_LEVEL + HYST_BAND ? 1'h0 : p);
    endfunction

    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'h0;
        @(posedge sys_clk);
        rd(OFS_HOLD_TIME, RST_HOLD_TIME);
        rd(OFS_ZERO_LEVEL, RST_ZERO_LEVEL);
        rd(8'h40, 32'h0);
        wr(OFS_STATUS, 16'hFFFF);
        rd(OFS_STATUS, 32'h00000107);
        wr(OFS_STOP_TIME, 16'h0001);
        wr(OFS_HOLD_TIME, 16'h0002);
        wr(OFS_FAST_TIME, 16'h0064);
        wr(OFS_FAST_LIMIT, 16'h0005);
        // feedback hovers around the zero level and its band
        repeat (40) begin
            x = $random(seed) % 200;
            fb_ofs <= x[15:0];
            repeat (3) @(posedge sys_clk);
            ez = nz(ez, x);
            chk({ez, 1'h1, ez, ~ez}, {speed_near_zero, demand_near_zero,
                motor_stopped_flag, not_motor_stopped_flag});
        end
        fb_ofs <= 16'h0;
        enable_in <= 1'h0;
        repeat (8) @(posedge sys_clk);
        chk(1, drive_ctl.loop_reset);
        enable_in <= 1'h1;
        wr(OFS_CONTROL, 16'h0001);
        run_cmd <= 1'h1;
        wc(1'h1, 20);
        repeat (5) @(posedge sys_clk);
        chk(4'hB, {drive_ctl.contactor_on, drive_ctl.firing_enable,
            drive_ctl.loop_quench, drive_ctl.run_led});
        speed_setpoint <= 16'sd300;
        repeat (6) @(posedge sys_clk);
        chk(1, drive_ctl.firing_enable);
        wr(OFS_FALL_RATE, 16'h01F4);
        run_cmd <= 1'h0;
        repeat (400) @(posedge sys_clk);
        chk(4'hB, {drive_ctl.contactor_on, drive_ctl.drive_enable, speed_demand === 16'sd0,
            current_command > 0 && current_command < 100});
        wc(1'h0, 200);
        chk(0, drive_ctl.drive_enable);
        cap = 16'($random(seed)) & 16'h1FFF;
        wr(OFS_FAST_CAP, cap);
        run_cmd <= 1'h1;
        wc(1'h1, 20);
        fast_stop_n <= 1'h0;
        repeat (10) @(posedge sys_clk);
        chk(cap, main_current_limit);
        override_limit_active <= 1'h1;
        repeat (3) @(posedge sys_clk);
        chk(override_current_limit, main_current_limit);
        wc(1'h0, 600);
        chk(1, speed_feedback > 16'sd200 && !drive_ctl.drive_enable);
        {fast_stop_n, override_limit_active, run_cmd} <= 3'h4;
        repeat (8) @(posedge sys_clk);
        run_cmd <= 1'h1;
        wc(1'h1, 20);
        freewheel_n <= 1'h0;
        wc(1'h0, 8);
        run_cmd <= 1'h0;
        repeat (8) @(posedge sys_clk);
        run_cmd <= 1'h1;
        repeat (20) @(posedge sys_clk);
        chk(0, drive_ctl.drive_enable);
        freewheel_n <= 1'h1;
        repeat (8) @(posedge sys_clk);
        chk(0, drive_ctl.contactor_on);
        conclude;
    end
endmodule

/* rtl/ssq_pkg.sv */
package ssq_pkg;

    // time base
    localparam int CLK_PERIOD_NS = 100;
    localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int TENTH_SEC_NS  = 100_000_000;
    localparam int TENTH_CYCLES  = TENTH_SEC_NS / CLK_PERIOD_NS;

    // percent values in units of 0.01 %
    localparam int          PCT_FULL       = 10000;
    localparam int          RAMP_STEP_CYC  = TENTH_CYCLES / PCT_FULL;
    localparam logic [15:0] HYST_BAND      = 16'h0032;
    localparam logic [15:0] EARLY_OFF_LVL  = 16'h0019;

    // register byte offsets
    localparam logic [7:0] OFS_STOP_TIME  = 8'h00;
    localparam logic [7:0] OFS_STOP_LIMIT = 8'h04;
    localparam logic [7:0] OFS_HOLD_TIME  = 8'h08;
    localparam logic [7:0] OFS_FALL_RATE  = 8'h0C;
    localparam logic [7:0] OFS_FAST_TIME  = 8'h10;
    localparam logic [7:0] OFS_FAST_LIMIT = 8'h14;
    localparam logic [7:0] OFS_FAST_CAP   = 8'h18;
    localparam logic [7:0] OFS_STOP_LEVEL = 8'h1C;
    localparam logic [7:0] OFS_ZERO_LEVEL = 8'h20;
    localparam logic [7:0] OFS_CONTROL    = 8'h24;
    localparam logic [7:0] OFS_STATUS     = 8'h28;

    // reset values (times in 0.1 s)
    localparam logic [15:0] RST_STOP_TIME  = 16'h0064;
    localparam logic [15:0] RST_STOP_LIMIT = 16'h0258;
    localparam logic [15:0] RST_HOLD_TIME  = 16'h000A;
    localparam logic [15:0] RST_FALL_RATE  = 16'h0000;
    localparam logic [15:0] RST_FAST_TIME  = 16'h0001;
    localparam logic [15:0] RST_FAST_LIMIT = 16'h0258;
    localparam logic [15:0] RST_FAST_CAP   = 16'h2710;
    localparam logic [15:0] RST_STOP_LEVEL = 16'h00C8;
    localparam logic [15:0] RST_ZERO_LEVEL = 16'h0064;
    localparam logic        RST_QUENCH_EN  = 1'b0;

    // control and status field positions
    localparam int CTL_QUENCH_BIT   = 0;
    localparam int STS_SPEED_ZERO   = 0;
    localparam int STS_DEMAND_ZERO  = 1;
    localparam int STS_STOPPED      = 2;
    localparam int STS_CONTACTOR    = 3;
    localparam int STS_DRIVE_EN     = 4;
    localparam int STS_STATE_LSB    = 8;

    typedef enum logic [2:0] {
        SEQ_LOCKOUT, SEQ_IDLE, SEQ_RUN, SEQ_NORMAL_RAMP, SEQ_HOLD, SEQ_FAST_RAMP
    } ssq_state_type;

    typedef struct packed {
        logic [15:0] stop_time;
        logic [15:0] stop_limit;
        logic [15:0] hold_time;
        logic [15:0] fall_rate;
        logic [15:0] fast_time;
        logic [15:0] fast_limit;
        logic [15:0] fast_cap;
        logic [15:0] stop_level;
        logic [15:0] zero_level;
        logic        quench_en;
    } ssq_cfg_type;

    typedef struct packed {
        logic contactor_on;
        logic drive_enable;
        logic firing_enable;
        logic loop_quench;
        logic loop_reset;
        logic run_led;
    } ssq_drive_type;

endpackage

/* rtl/ssq_timer.sv */
`timescale 1ns/1ps
module ssq_timer
    import ssq_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  wire logic        active,
    input  wire logic        tick,
    input  wire logic [15:0] duration,
    output logic             expired
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic        armed;
    logic        next_armed;

    always_comb begin
        next_count = count;
        next_armed = armed;
        if (start) begin
            next_count = duration;
            next_armed = 1'b1;
        end else if (!active) begin
            next_armed = 1'b0;
        end else if (tick && count != 16'h0000) begin
            next_count = count - 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count <= 16'h0000;
            armed <= 1'b0;
        end else begin
            count <= next_count;
            armed <= next_armed;
        end
    end

    // a zero duration expires at once
    assign expired = armed && active && count == 16'h0000;

endmodule

/* rtl/ssq_top.sv */
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module ssq_top
    import ssq_pkg::*;
#(
    parameter int TICK_CYCLES = TENTH_CYCLES,
    parameter int STEP_CYCLES = RAMP_STEP_CYC,
    parameter int FALL_CYCLES = CLK_HZ
)
(
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    input  wire logic               run_cmd,
    input  wire logic               fast_stop_n,
    input  wire logic               freewheel_n,
    input  wire logic               enable_in,
    input  wire logic signed [15:0] speed_feedback,
    input  wire logic signed [15:0] speed_setpoint,
    input  wire logic signed [15:0] standstill_demand,
    input  wire logic signed [15:0] current_demand,
    input  wire logic [15:0]        normal_current_limit,
    input  wire logic [15:0]        override_current_limit,
    input  wire logic               override_limit_active,
    output logic signed [15:0]      speed_demand,
    output logic signed [15:0]      current_command,
    output logic [15:0]             main_current_limit,
    output ssq_drive_type           drive_ctl,
    output logic                    speed_near_zero,
    output logic                    demand_near_zero,
    output logic                    motor_stopped_flag,
    output logic                    not_motor_stopped_flag,
    output logic                    zero_speed_relay
);
    // pin synchronisers: run, fast stop, freewheel, enable
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_meta <= 4'hE;
            pin_sync <= 4'hE;
        end else begin
            pin_meta <= {enable_in, freewheel_n, fast_stop_n, run_cmd};
            pin_sync <= pin_meta;
        end
    end

    logic run_s;
    logic fast_act;
    logic free_act;
    logic enable_s;
    assign run_s    = pin_sync[0];
    assign fast_act = !pin_sync[1];
    assign free_act = !pin_sync[2];
    assign enable_s = pin_sync[3];

    // register file
    ssq_cfg_type cfg;
    ssq_cfg_type next_cfg;
    logic [31:0] next_rdata;
    logic [15:0] status_word;

    always_comb begin
        next_cfg = cfg;
        if (reg_wr) begin
            if (reg_addr == OFS_STOP_TIME) begin
                next_cfg.stop_time = reg_wdata[15:0];
            end else if (reg_addr == OFS_STOP_LIMIT) begin
                next_cfg.stop_limit = reg_wdata[15:0];
            end else if (reg_addr == OFS_HOLD_TIME) begin
                next_cfg.hold_time = reg_wdata[15:0];
            end else if (reg_addr == OFS_FALL_RATE) begin
                next_cfg.fall_rate = reg_wdata[15:0];
            end else if (reg_addr == OFS_FAST_TIME) begin
                next_cfg.fast_time = reg_wdata[15:0];
            end else if (reg_addr == OFS_FAST_LIMIT) begin
                next_cfg.fast_limit = reg_wdata[15:0];
            end else if (reg_addr == OFS_FAST_CAP) begin
                next_cfg.fast_cap = reg_wdata[15:0];
            end else if (reg_addr == OFS_STOP_LEVEL) begin
                next_cfg.stop_level = reg_wdata[15:0];
            end else if (reg_addr == OFS_ZERO_LEVEL) begin
                next_cfg.zero_level = reg_wdata[15:0];
            end else if (reg_addr == OFS_CONTROL) begin
                next_cfg.quench_en = reg_wdata[CTL_QUENCH_BIT];
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == OFS_STOP_TIME) begin
                next_rdata[15:0] = cfg.stop_time;
            end else if (reg_addr == OFS_STOP_LIMIT) begin
                next_rdata[15:0] = cfg.stop_limit;
            end else if (reg_addr == OFS_HOLD_TIME) begin
                next_rdata[15:0] = cfg.hold_time;
            end else if (reg_addr == OFS_FALL_RATE) begin
                next_rdata[15:0] = cfg.fall_rate;
            end else if (reg_addr == OFS_FAST_TIME) begin
                next_rdata[15:0] = cfg.fast_time;
            end else if (reg_addr == OFS_FAST_LIMIT) begin
                next_rdata[15:0] = cfg.fast_limit;
            end else if (reg_addr == OFS_FAST_CAP) begin
                next_rdata[15:0] = cfg.fast_cap;
            end else if (reg_addr == OFS_STOP_LEVEL) begin
                next_rdata[15:0] = cfg.stop_level;
            end else if (reg_addr == OFS_ZERO_LEVEL) begin
                next_rdata[15:0] = cfg.zero_level;
            end else if (reg_addr == OFS_CONTROL) begin
                next_rdata[CTL_QUENCH_BIT] = cfg.quench_en;
            end else if (reg_addr == OFS_STATUS) begin
                next_rdata[15:0] = status_word;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg <= '{RST_STOP_TIME, RST_STOP_LIMIT, RST_HOLD_TIME, RST_FALL_RATE,
                     RST_FAST_TIME, RST_FAST_LIMIT, RST_FAST_CAP, RST_STOP_LEVEL,
                     RST_ZERO_LEVEL, RST_QUENCH_EN};
            reg_rdata <= 32'h0000_0000;
        end else begin
            cfg       <= next_cfg;
            reg_rdata <= next_rdata;
        end
    end

    // standstill detection
    logic [15:0] fb_mag;
    logic [15:0] dem_mag;
    logic [16:0] clear_level;
    logic        next_speed_zero;
    logic        next_demand_zero;

    assign fb_mag      = speed_feedback[15] ? 16'(-speed_feedback) : 16'(speed_feedback);
    assign dem_mag     = standstill_demand[15] ? 16'(-standstill_demand)
                                               : 16'(standstill_demand);
    assign clear_level = {1'b0, cfg.zero_level} + {1'b0, HYST_BAND};

    always_comb begin
        next_speed_zero  = speed_near_zero;
        next_demand_zero = demand_near_zero;
        if (!speed_near_zero && fb_mag < cfg.zero_level) begin
            next_speed_zero = 1'b1;
        end else if (speed_near_zero && {1'b0, fb_mag} > clear_level) begin
            next_speed_zero = 1'b0;
        end
        if (!demand_near_zero && dem_mag < cfg.zero_level) begin
            next_demand_zero = 1'b1;
        end else if (demand_near_zero && {1'b0, dem_mag} > clear_level) begin
            next_demand_zero = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            speed_near_zero  <= 1'b0;
            demand_near_zero <= 1'b0;
        end else begin
            speed_near_zero  <= next_speed_zero;
            demand_near_zero <= next_demand_zero;
        end
    end

    assign motor_stopped_flag = speed_near_zero && demand_near_zero;
    assign not_motor_stopped_flag  = !motor_stopped_flag;
    assign zero_speed_relay   = speed_near_zero;

    // 0.1 s tick and ramp step prescaler
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic [15:0] step_cnt;
    logic [15:0] next_step_cnt;
    logic        tick;
    logic        step_pulse;

    assign tick       = tick_cnt == 32'(TICK_CYCLES - 1);
    assign step_pulse = step_cnt == 16'(STEP_CYCLES - 1);

    always_comb begin
        next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        next_step_cnt = step_pulse ? 16'h0000 : step_cnt + 16'h0001;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tick_cnt <= 32'h0000_0000;
            step_cnt <= 16'h0000;
        end else begin
            tick_cnt <= next_tick_cnt;
            step_cnt <= next_step_cnt;
        end
    end

    // stop sequencer
    ssq_state_type state;
    ssq_state_type next_state;
    logic          at_stop_level;
    logic          timeout_start;
    logic          hold_start;
    logic          timeout_done;
    logic          hold_done;
    logic [15:0]   timeout_len;
    logic          early_off;

    assign at_stop_level = fb_mag <= cfg.stop_level;
    assign early_off     = cfg.stop_level > EARLY_OFF_LVL && cfg.fall_rate != 16'h0000;

    always_comb begin
        next_state    = state;
        timeout_start = 1'b0;
        hold_start    = 1'b0;
        timeout_len   = cfg.stop_limit;
        case (state)
            SEQ_LOCKOUT: begin
                // a stop latches until run is taken away while freewheel is not active
                if (!run_s) begin
                    next_state = SEQ_IDLE;
                end
            end
            SEQ_IDLE: begin
                if (run_s && (free_act || fast_act)) begin
                    next_state = SEQ_LOCKOUT;
                end else if (run_s) begin
                    next_state = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (fast_act) begin
                    next_state    = SEQ_FAST_RAMP;
                    timeout_start = 1'b1;
                    timeout_len   = cfg.fast_limit;
                end else if (!run_s) begin
                    next_state    = SEQ_NORMAL_RAMP;
                    timeout_start = 1'b1;
                end
            end
            SEQ_NORMAL_RAMP: begin
                if (fast_act) begin
                    next_state    = SEQ_FAST_RAMP;
                    timeout_start = 1'b1;
                    timeout_len   = cfg.fast_limit;
                end else if (timeout_done) begin
                    next_state = SEQ_LOCKOUT;
                end else if (at_stop_level && speed_demand == 16'sh0000) begin
                    next_state = SEQ_HOLD;
                    hold_start = 1'b1;
                end
            end
            SEQ_HOLD: begin
                if (hold_done || !enable_s) begin
                    next_state = SEQ_LOCKOUT;
                end
            end
            SEQ_FAST_RAMP: begin
                if (timeout_done || at_stop_level) begin
                    next_state = SEQ_LOCKOUT;
                end
            end
            default: begin
                next_state = SEQ_LOCKOUT;
            end
        endcase
        if (free_act && state != SEQ_IDLE) begin
            next_state = SEQ_LOCKOUT;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= SEQ_LOCKOUT;
        end else begin
            state <= next_state;
        end
    end

    ssq_timer u_timeout (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .start    (timeout_start),
        .active   (state == SEQ_NORMAL_RAMP || state == SEQ_FAST_RAMP),
        .tick     (tick),
        .duration (timeout_len),
        .expired  (timeout_done)
    );

    ssq_timer u_hold (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .start    (hold_start),
        .active   (state == SEQ_HOLD),
        .tick     (tick),
        .duration (cfg.hold_time),
        .expired  (hold_done)
    );

    // speed demand ramp toward zero
    logic [15:0]        ramp_cnt;
    logic [15:0]        next_ramp_cnt;
    logic signed [15:0] next_demand;
    logic [15:0]        ramp_len;
    logic               ramping;

    assign ramping  = state == SEQ_NORMAL_RAMP || state == SEQ_FAST_RAMP;
    assign ramp_len = state == SEQ_FAST_RAMP ? cfg.fast_time : cfg.stop_time;

    always_comb begin
        next_demand   = speed_demand;
        next_ramp_cnt = ramp_cnt;
        if (state == SEQ_RUN) begin
            next_demand   = speed_setpoint;
            next_ramp_cnt = 16'h0000;
        end else if (ramping) begin
            // one 0.01 % step per ramp_len step pulses gives full scale in ramp_len tenths
            if (step_pulse) begin
                if (ramp_cnt + 16'h0001 >= ramp_len) begin
                    next_ramp_cnt = 16'h0000;
                    if (speed_demand > 16'sh0000) begin
                        next_demand = speed_demand - 16'sh0001;
                    end else if (speed_demand < 16'sh0000) begin
                        next_demand = speed_demand + 16'sh0001;
                    end
                end else begin
                    next_ramp_cnt = ramp_cnt + 16'h0001;
                end
            end
        end else begin
            next_demand   = 16'sh0000;
            next_ramp_cnt = 16'h0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            speed_demand <= 16'sh0000;
            ramp_cnt     <= 16'h0000;
        end else begin
            speed_demand <= next_demand;
            ramp_cnt     <= next_ramp_cnt;
        end
    end

    // drive control outputs
    ssq_drive_type next_drive;
    logic          quench;

    assign quench = motor_stopped_flag && cfg.quench_en && state == SEQ_RUN;

    always_comb begin
        next_drive              = '0;
        next_drive.contactor_on = state == SEQ_RUN || ramping || state == SEQ_HOLD;
        next_drive.drive_enable = next_drive.contactor_on && enable_s
                                  && !(state == SEQ_HOLD && early_off);
        next_drive.firing_enable = next_drive.drive_enable && !quench;
        next_drive.loop_quench   = quench || !next_drive.drive_enable;
        next_drive.loop_reset    = !enable_s;
        next_drive.run_led       = next_drive.contactor_on;
        if (free_act) begin
            next_drive = '0;
            next_drive.loop_quench = 1'b1;
            next_drive.loop_reset  = !enable_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            drive_ctl <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        end else begin
            drive_ctl <= next_drive;
        end
    end

    // current fall when the loop is off, and the fast stop cap
    logic [24:0]        fall_acc;
    logic [24:0]        next_fall_acc;
    logic signed [15:0] next_current;
    logic [15:0]        next_limit;

    always_comb begin
        next_current  = current_command;
        next_fall_acc = fall_acc;
        if (!drive_ctl.loop_quench) begin
            next_current  = current_demand;
            next_fall_acc = 25'h0000000;
        end else if (cfg.fall_rate == 16'h0000) begin
            next_current = 16'sh0000;
        end else if (fall_acc + {9'h000, cfg.fall_rate} >= 25'(FALL_CYCLES)) begin
            // accumulate rate each cycle, step once per full second's worth
            next_fall_acc = fall_acc + {9'h000, cfg.fall_rate} - 25'(FALL_CYCLES);
            if (current_command > 16'sh0000) begin
                next_current = current_command - 16'sh0001;
            end else if (current_command < 16'sh0000) begin
                next_current = current_command + 16'sh0001;
            end
        end else begin
            next_fall_acc = fall_acc + {9'h000, cfg.fall_rate};
        end
        next_limit = normal_current_limit;
        if (state == SEQ_FAST_RAMP) begin
            next_limit = override_limit_active ? override_current_limit
                                               : cfg.fast_cap;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            current_command    <= 16'sh0000;
            fall_acc           <= 25'h0000000;
            main_current_limit <= 16'h0000;
        end else begin
            current_command    <= next_current;
            fall_acc           <= next_fall_acc;
            main_current_limit <= next_limit;
        end
    end

    always_comb begin
        status_word                   = 16'h0000;
        status_word[STS_SPEED_ZERO]   = speed_near_zero;
        status_word[STS_DEMAND_ZERO]  = demand_near_zero;
        status_word[STS_STOPPED]      = motor_stopped_flag;
        status_word[STS_CONTACTOR]    = drive_ctl.contactor_on;
        status_word[STS_DRIVE_EN]     = drive_ctl.drive_enable;
        status_word[STS_STATE_LSB+:3] = state;
    end

endmodule
